/* pixel_framer_pkg.sv */
package pixel_framer_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NCH  = 4;
  localparam int PXW  = 10;
  localparam int ERRW = 8;
  localparam int NREG = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BLACKCAL = 8'h80;
  localparam logic [7:0] ADDR_FORMAT   = 8'h81;
  localparam logic [7:0] ADDR_TRAIN    = 8'h82;
  localparam logic [7:0] ADDR_FRAME    = 8'h83;
  localparam logic [7:0] ADDR_DARK     = 8'h84;
  localparam logic [7:0] ADDR_IMG      = 8'h85;
  localparam logic [7:0] ADDR_CHK      = 8'h86;
  localparam logic [7:0] ADDR_ALIGN    = 8'h87;
  localparam logic [7:0] ADDR_ERR      = 8'h88;
  localparam logic [7:0] ADDR_SPARE    = 8'h89;

  // ----------------------------------------------------------------
  // Reset values, indexed by offset minus ADDR_BLACKCAL
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_RST [NREG] = '{16'h4008, 16'hc001, 16'h03a6, 16'h002a,
                                             16'h0015, 16'h0035, 16'h0059, 16'h03a6};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int F_TARGET_LSB  = 0;
  localparam int F_SAMPLES_LSB = 8;
  localparam int F_AUTO        = 0;
  localparam int F_MANUAL_LSB  = 1;
  localparam int F_SUB         = 10;
  localparam int F_NARROW      = 13;
  localparam int F_FPASS       = 14;
  localparam int F_LPASS       = 15;
  localparam int M_KIND        = 9;
  localparam int M_START       = 8;
  localparam int M_END         = 7;

  typedef struct packed {
    logic [7:0] target;
    logic [2:0] samples;
    logic       auto_en;
    logic [8:0] manual;
    logic       sub;
    logic       narrow_word_select;
    logic       dark_row_frame_flag_pass;
    logic       dark_row_line_flag_pass;
    logic [9:0] train;
    logic [6:0] frame_low;
    logic [9:0] dark_pixel_marker;
    logic [9:0] img;
    logic [9:0] chk;
    logic [9:0] alignment_marker;
  } cfg_s;

  // Frame/line marker: kind high means frame
  function automatic logic [9:0] marker(input logic [6:0] low, input logic kind, input logic st,
                                        input logic en);
    marker = {kind, st, en, low};
  endfunction : marker

endpackage : pixel_framer_pkg

/* pixel_link_if.sv */
`timescale 1ns/1ns
interface pixel_link_if (
  input logic link_clk
);
  logic [pixel_framer_pkg::NCH*pixel_framer_pkg::PXW-1:0] data;
  logic [pixel_framer_pkg::PXW-1:0]                       sync;
  logic                                                   frame_valid;
  logic                                                   line_valid;

  modport tx (input link_clk, output data, output sync, output frame_valid, output line_valid);
  modport rx (input link_clk, input data, input sync, input frame_valid, input line_valid);
endinterface : pixel_link_if

/* pixel_output_framer_blackcal.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Auto calibration runs when enable set, reset one
// - Manual offset replaces auto value when disabled
// - Manual offset added, or subtracted when sign set
// - Width bit selects 10 or 8 bit words
// - Frame flag shown on dark rows if passed
// - Line flag shown on dark rows if passed
// - Idle sends training word on every channel
// - Receiver aligns on idle word before decoding
// - Marker is seven low bits plus kind/start/end
// - Dark pixels tagged with dark marker code
// - Image pixels tagged with image marker code
// - Checksum words tagged with checksum marker code
// - Training words tagged with alignment marker code
// - Per-channel flag when dark samples fall short
// - Calibration steers dark level toward target
// - Averaged dark samples equal two to field
module pixel_output_framer_blackcal (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  output logic                        reg_rvalid,
  output logic                        cfg_busy,
  input  wire logic                   src_valid,
  output logic                        src_ready,
  input  wire logic                   src_black,
  input  wire logic                   src_first,
  input  wire logic                   src_last,
  input  wire logic                   src_frame_first,
  input  wire logic                   src_frame_last,
  input  wire logic [4*10-1:0]        src_data,
  pixel_link_if.tx                    lnk
);

  // ----------------------------------------------------------------
  // Register file, core clock
  // ----------------------------------------------------------------
  function automatic logic is_rw(input logic [7:0] a);
    is_rw = (a[7:3] == pixel_framer_pkg::ADDR_BLACKCAL[7:3]);
  endfunction : is_rw

  logic [15:0]           regs_q [pixel_framer_pkg::NREG];
  logic [15:0]           regs_d [pixel_framer_pkg::NREG];
  logic                  tog_q, tog_d, busy_q, busy_d, rvalid_q, rvalid_d;
  logic [15:0]           rdata_q, rdata_d;
  logic                  ack_s1_q, ack_s2_q;
  logic [3:0]            err_s1_q, err_s2_q;
  pixel_framer_pkg::cfg_s cfg_core;
  logic                  ack_q;
  logic [3:0]            err_q;

  always_comb begin
    cfg_core.target                   = regs_q[0][pixel_framer_pkg::F_TARGET_LSB +: 8];
    cfg_core.samples                  = regs_q[0][pixel_framer_pkg::F_SAMPLES_LSB +: 3];
    cfg_core.auto_en                  = regs_q[1][pixel_framer_pkg::F_AUTO];
    cfg_core.manual                   = regs_q[1][pixel_framer_pkg::F_MANUAL_LSB +: 9];
    cfg_core.sub                      = regs_q[1][pixel_framer_pkg::F_SUB];
    cfg_core.narrow_word_select       = regs_q[1][pixel_framer_pkg::F_NARROW];
    cfg_core.dark_row_frame_flag_pass = regs_q[1][pixel_framer_pkg::F_FPASS];
    cfg_core.dark_row_line_flag_pass  = regs_q[1][pixel_framer_pkg::F_LPASS];
    cfg_core.train                    = regs_q[2][9:0];
    cfg_core.frame_low                = regs_q[3][6:0];
    cfg_core.dark_pixel_marker        = regs_q[4][9:0];
    cfg_core.img                      = regs_q[5][9:0];
    cfg_core.chk                      = regs_q[6][9:0];
    cfg_core.alignment_marker         = regs_q[7][9:0];
  end

  always_comb begin
    regs_d   = regs_q;
    tog_d    = tog_q;
    busy_d   = busy_q;
    rvalid_d = 1'b0;
    rdata_d  = rdata_q;
    // Writes during a transfer are dropped so the bundle stays stable while the link side samples it
    if (reg_wr && !busy_q && is_rw(reg_addr)) begin
      regs_d[reg_addr[2:0]] = reg_wdata;
      tog_d  = ~tog_q;
      busy_d = 1'b1;
    end else if (busy_q && (ack_s2_q == tog_q)) begin
      busy_d = 1'b0;
    end
    if (reg_rd) begin
      rvalid_d = 1'b1;
      if (is_rw(reg_addr)) begin
        rdata_d = regs_q[reg_addr[2:0]];
      end else if (reg_addr == pixel_framer_pkg::ADDR_ERR) begin
        rdata_d = {12'h000, err_s2_q};
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < pixel_framer_pkg::NREG; i++) begin
        regs_q[i] <= pixel_framer_pkg::REG_RST[i];
      end
      tog_q    <= 1'b0;
      busy_q   <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= 16'h0000;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      err_s1_q <= 4'h0;
      err_s2_q <= 4'h0;
    end else if (clk_en) begin
      regs_q   <= regs_d;
      tog_q    <= tog_d;
      busy_q   <= busy_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      // Flags change only at line ends, so a per-bit level sync is enough here
      err_s1_q <= err_q;
      err_s2_q <= err_s1_q;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign cfg_busy   = busy_q;

  // ----------------------------------------------------------------
  // Link clock reset and crossings
  // ----------------------------------------------------------------
  logic lr1_q, lr2_q, en_s1_q, en_s2_q, tog_s1_q, tog_s2_q;

  always_ff @(posedge lnk.link_clk or negedge resetn) begin
    if (!resetn) begin
      lr1_q    <= 1'b0;
      lr2_q    <= 1'b0;
      en_s1_q  <= 1'b0;
      en_s2_q  <= 1'b0;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
    end else begin
      lr1_q    <= 1'b1;
      lr2_q    <= lr1_q;
      en_s1_q  <= clk_en;
      en_s2_q  <= en_s1_q;
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Framer and calibration, link clock
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LINE = 2'b01, ST_CHECK = 2'b11} st_e;

  function automatic logic [9:0] correct(input logic [9:0] px, input logic signed [11:0] ofs);
    logic signed [12:0] s;
    s = $signed({3'b000, px}) + $signed({ofs[11], ofs});
    if (s < 13'sd0) correct = 10'h000;
    else if (s > 13'sd1023) correct = 10'h3ff;
    else correct = s[9:0];
  endfunction : correct

  st_e                    st_q, st_d;
  pixel_framer_pkg::cfg_s cfg_q, cfg_d;
  logic                   ack_d, ready_q, ready_d, fv_q, fv_d, lv_q, lv_d;
  logic                   inf_q, inf_d, fl_q, fl_d, blk_q, blk_d;
  logic [39:0]            data_q, data_d;
  logic [9:0]             sync_q, sync_d;
  logic [16:0]            acc_q [4];
  logic [16:0]            acc_d [4];
  logic signed [11:0]     ofs_q [4];
  logic signed [11:0]     ofs_d [4];
  logic [9:0]             chk_q [4];
  logic [9:0]             chk_d [4];
  logic [7:0]             cnt_q, cnt_d;
  logic [3:0]             err_d;

  always_comb begin
    logic [7:0]         need;
    logic [7:0]         cb;
    logic [16:0]        ab;
    logic [9:0]         px, w;
    logic signed [11:0] so;
    need = 8'h00; cb = 8'h00; ab = 17'h00000; px = 10'h000; w = 10'h000; so = 12'sh000;
    st_d = st_q; cfg_d = cfg_q; ack_d = ack_q; ready_d = ready_q; lv_d = 1'b0;
    inf_d = inf_q; fl_d = fl_q; blk_d = blk_q; data_d = data_q; sync_d = sync_q;
    acc_d = acc_q; ofs_d = ofs_q; chk_d = chk_q; cnt_d = cnt_q; err_d = err_q;
    if (tog_s2_q != ack_q) begin
      cfg_d = cfg_core;
      ack_d = tog_s2_q;
    end
    need = 8'h01 << cfg_q.samples;
    case (st_q)
      ST_CHECK: begin
        for (int c = 0; c < 4; c++) data_d[c*10 +: 10] = chk_q[c];
        sync_d  = cfg_q.chk;
        if (fl_q) inf_d = 1'b0;
        ready_d = 1'b1;
        st_d    = ST_IDLE;
      end
      ST_IDLE, ST_LINE: begin
        if (src_valid) begin
          if (src_first) begin
            blk_d = src_black;
            if (src_frame_first) inf_d = 1'b1;
          end
          cb = src_first ? 8'h00 : cnt_q;
          if (src_black && cb < need) cnt_d = cb + 8'h01;
          else cnt_d = cb;
          for (int c = 0; c < 4; c++) begin
            px = src_data[c*10 +: 10];
            if (cfg_q.auto_en) so = ofs_q[c];
            else if (cfg_q.sub) so = -$signed({3'b000, cfg_q.manual});
            else so = $signed({3'b000, cfg_q.manual});
            w = correct(px, so);
            if (cfg_q.narrow_word_select) w = {2'b00, w[9:2]};
            data_d[c*10 +: 10] = w;
            chk_d[c] = (src_first ? 10'h000 : chk_q[c]) ^ w;
            ab = src_first ? 17'h00000 : acc_q[c];
            if (src_black && cb < need) ab = ab + {7'h00, px};
            acc_d[c] = ab;
            if (src_black && src_last) begin
              if (cnt_d < need) begin
                err_d[c] = 1'b1;
              end else begin
                err_d[c] = 1'b0;
                ofs_d[c] = $signed({4'h0, cfg_q.target}) - $signed({2'b00, 10'(ab >> cfg_q.samples)});
              end
            end
          end
          if (src_first) sync_d = pixel_framer_pkg::marker(cfg_q.frame_low, src_frame_first, 1'b1, 1'b0);
          else if (src_last) sync_d = pixel_framer_pkg::marker(cfg_q.frame_low, src_frame_last, 1'b0, 1'b1);
          else if (src_black) sync_d = cfg_q.dark_pixel_marker;
          else sync_d = cfg_q.img;
          lv_d = !(src_black && !cfg_q.dark_row_line_flag_pass);
          if (src_last) begin
            fl_d    = src_frame_last;
            ready_d = 1'b0;
            st_d    = ST_CHECK;
          end else begin
            st_d = ST_LINE;
          end
        end else begin
          data_d = {4{cfg_q.train}};
          sync_d = cfg_q.alignment_marker;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    fv_d = inf_d && !(blk_d && !cfg_q.dark_row_frame_flag_pass);
  end

  always_ff @(posedge lnk.link_clk or negedge lr2_q) begin
    if (!lr2_q) begin
      st_q    <= ST_IDLE;
      cfg_q   <= pixel_framer_pkg::cfg_s'({8'h08, 3'h0, 1'b1, 9'h000, 1'b0, 1'b0, 1'b1, 1'b1,
                                           10'h3a6, 7'h2a, 10'h015, 10'h035, 10'h059, 10'h3a6});
      ack_q   <= 1'b0;
      ready_q <= 1'b1;
      fv_q    <= 1'b0;
      lv_q    <= 1'b0;
      inf_q   <= 1'b0;
      fl_q    <= 1'b0;
      blk_q   <= 1'b0;
      data_q  <= {4{10'h3a6}};
      sync_q  <= 10'h3a6;
      cnt_q   <= 8'h00;
      err_q   <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        acc_q[c] <= 17'h00000;
        ofs_q[c] <= 12'sh000;
        chk_q[c] <= 10'h000;
      end
    end else if (en_s2_q) begin
      st_q <= st_d; cfg_q <= cfg_d; ack_q <= ack_d; ready_q <= ready_d; fv_q <= fv_d; lv_q <= lv_d;
      inf_q <= inf_d; fl_q <= fl_d; blk_q <= blk_d; data_q <= data_d; sync_q <= sync_d;
      cnt_q <= cnt_d; err_q <= err_d; acc_q <= acc_d; ofs_q <= ofs_d; chk_q <= chk_d;
    end
  end

  assign src_ready       = ready_q;
  assign lnk.data        = data_q;
  assign lnk.sync        = sync_q;
  assign lnk.frame_valid = fv_q;
  assign lnk.line_valid  = lv_q;

endmodule : pixel_output_framer_blackcal

/* pixel_link_receiver.sv */
`timescale 1ns/1ns
module pixel_link_receiver (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  input  wire pixel_framer_pkg::cfg_s cfg_in,
  input  wire logic                   cfg_load,
  output logic                        cfg_busy,
  output logic                        rx_locked,
  output logic                        rx_valid,
  output logic                        rx_black,
  output logic                        rx_first,
  output logic                        rx_last,
  output logic                        rx_frame,
  output logic [39:0]                 rx_data,
  output logic                        rx_chk_valid,
  output logic                        rx_chk_ok,
  pixel_link_if.rx                    lnk
);

  // ----------------------------------------------------------------
  // Code load handshake, core clock
  // ----------------------------------------------------------------
  logic tog_q, busy_q, ack_s1_q, ack_s2_q, ack_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tog_q    <= 1'b0;
      busy_q   <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else if (clk_en) begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      if (cfg_load && !busy_q) begin
        tog_q  <= ~tog_q;
        busy_q <= 1'b1;
      end else if (busy_q && ack_s2_q == tog_q) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign cfg_busy = busy_q;

  // ----------------------------------------------------------------
  // Link clock reset and crossings
  // ----------------------------------------------------------------
  logic lr1_q, lr2_q, en_s1_q, en_s2_q, tog_s1_q, tog_s2_q;

  always_ff @(posedge lnk.link_clk or negedge resetn) begin
    if (!resetn) begin
      lr1_q <= 1'b0; lr2_q <= 1'b0; en_s1_q <= 1'b0; en_s2_q <= 1'b0; tog_s1_q <= 1'b0; tog_s2_q <= 1'b0;
    end else begin
      lr1_q <= 1'b1; lr2_q <= lr1_q; en_s1_q <= clk_en; en_s2_q <= en_s1_q; tog_s1_q <= tog_q; tog_s2_q <= tog_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Decoder, link clock
  // ----------------------------------------------------------------
  typedef enum logic {ST_SEEK = 1'b0, ST_LOCK = 1'b1} st_e;

  st_e                    st_q, st_d;
  pixel_framer_pkg::cfg_s cfg_q, cfg_d;
  logic                   ack_d, val_d, blk_d, fst_d, lst_d, frm_d, cv_d, cok_d;
  logic                   val_q, blk_q, fst_q, lst_q, frm_q, cv_q, cok_q;
  logic [39:0]            dat_q, dat_d, sum_q, sum_d;

  always_comb begin
    st_d = st_q; cfg_d = cfg_q; ack_d = ack_q; sum_d = sum_q; dat_d = dat_q;
    val_d = 1'b0; blk_d = 1'b0; fst_d = 1'b0; lst_d = 1'b0; frm_d = frm_q; cv_d = 1'b0; cok_d = cok_q;
    if (tog_s2_q != ack_q) begin
      cfg_d = cfg_in;
      ack_d = tog_s2_q;
    end
    case (st_q)
      ST_SEEK: begin
        // Nothing is decoded until the idle word is seen on every channel
        if (lnk.sync == cfg_q.alignment_marker && lnk.data == {4{cfg_q.train}}) st_d = ST_LOCK;
      end
      ST_LOCK: begin
        if (lnk.sync == cfg_q.alignment_marker) begin
          st_d = ST_LOCK;
        end else if (lnk.sync == cfg_q.chk) begin
          cv_d  = 1'b1;
          cok_d = (lnk.data == sum_q);
        end else if (lnk.sync == cfg_q.dark_pixel_marker || lnk.sync == cfg_q.img) begin
          val_d = 1'b1;
          blk_d = (lnk.sync == cfg_q.dark_pixel_marker);
          dat_d = lnk.data;
          sum_d = sum_q ^ lnk.data;
        end else if (lnk.sync[6:0] == cfg_q.frame_low) begin
          val_d = 1'b1;
          fst_d = lnk.sync[pixel_framer_pkg::M_START];
          lst_d = lnk.sync[pixel_framer_pkg::M_END];
          frm_d = lnk.sync[pixel_framer_pkg::M_KIND];
          dat_d = lnk.data;
          sum_d = (fst_d ? 40'h00_0000_0000 : sum_q) ^ lnk.data;
        end else begin
          // An unknown code means the word boundary was lost
          st_d = ST_SEEK;
        end
      end
      default: st_d = ST_SEEK;
    endcase
  end

  always_ff @(posedge lnk.link_clk or negedge lr2_q) begin
    if (!lr2_q) begin
      st_q  <= ST_SEEK;
      cfg_q <= pixel_framer_pkg::cfg_s'({8'h08, 3'h0, 1'b1, 9'h000, 1'b0, 1'b0, 1'b1, 1'b1,
                                         10'h3a6, 7'h2a, 10'h015, 10'h035, 10'h059, 10'h3a6});
      ack_q <= 1'b0; val_q <= 1'b0; blk_q <= 1'b0; fst_q <= 1'b0; lst_q <= 1'b0; frm_q <= 1'b0;
      cv_q  <= 1'b0; cok_q <= 1'b0; dat_q <= 40'h00_0000_0000; sum_q <= 40'h00_0000_0000;
    end else if (en_s2_q) begin
      st_q <= st_d; cfg_q <= cfg_d; ack_q <= ack_d; val_q <= val_d; blk_q <= blk_d; fst_q <= fst_d;
      lst_q <= lst_d; frm_q <= frm_d; cv_q <= cv_d; cok_q <= cok_d; dat_q <= dat_d; sum_q <= sum_d;
    end
  end

  assign rx_locked    = (st_q == ST_LOCK);
  assign rx_valid     = val_q;
  assign rx_black     = blk_q;
  assign rx_first     = fst_q;
  assign rx_last      = lst_q;
  assign rx_frame     = frm_q;
  assign rx_data      = dat_q;
  assign rx_chk_valid = cv_q;
  assign rx_chk_ok    = cok_q;

endmodule : pixel_link_receiver

/* pixel_link_asserts.sv */
`timescale 1ns/1ns
module pixel_link_asserts (
  input wire logic        link_clk,
  input wire logic        resetn,
  input wire logic [39:0] data,
  input wire logic [9:0]  sync,
  input wire logic        frame_valid,
  input wire logic        line_valid
);
  // ------------------------------------------------
  // Link framing
  // ------------------------------------------------
  // Codes held at reset values; retuning them would need parameters here
  localparam logic [9:0] ALIGN = 10'h3a6;
  localparam logic [9:0] CHK   = 10'h059;
  sequence end_s;
    sync[8:7] == 2'b01 && sync[6:0] == 7'h2a;
  endsequence
  sequence start_s;
    sync[8] && sync[6:0] == 7'h2a;
  endsequence
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!resetn);
  idle_word_a: assert property (sync == ALIGN |-> data == {4{ALIGN}})
    else $error("idle data wrong");
  idle_lines_a: assert property (sync == ALIGN |-> !line_valid)
    else $error("line flag during idle");
  chk_after_end_a: assert property (end_s |=> sync == CHK)
    else $error("no checksum after line end");
  chk_lv_low_a: assert property (sync == CHK |-> !line_valid)
    else $error("line flag on checksum");
  after_chk_a: assert property (sync == CHK |=> (sync == ALIGN) or start_s)
    else $error("bad word after checksum");
  lv_start_a: assert property ($rose(line_valid) |-> start_s)
    else $error("line flag without start marker");
  fv_start_a: assert property ($rose(frame_valid) |-> start_s)
    else $error("frame flag without start marker");
  pixel_code_a: assert property (start_s |=> (sync == 10'h035) or (sync == 10'h015) or end_s or (sync == CHK))
    else $error("bad code after start");
endmodule : pixel_link_asserts

/* pixel_output_framer_blackcal_tb.sv */
`timescale 1ns/1ns
module pixel_output_framer_blackcal_tb;
  logic                   core_clk, link_clk, resetn, reg_wr, reg_rd, cfg_load, lv_seen;
  logic                   clk_en, src_frame_first, src_frame_last, rx_frame;
  logic                   src_valid, src_black, src_first, src_last, reg_rvalid, cfg_busy, src_ready;
  logic                   rx_locked, rx_valid, rx_black, rx_chk_valid, rx_chk_ok;
  logic [7:0]             reg_addr;
  logic [15:0]            reg_wdata, reg_rdata;
  logic [39:0]            src_data, rx_data;
  pixel_framer_pkg::cfg_s cfg;
  logic [9:0]             got[$];
  int                     bad_count, checked, nblk, nchk;
  always #20 core_clk = ~core_clk;
  always begin
    #62 link_clk = ~link_clk;
    #63 link_clk = ~link_clk;
  end
  pixel_link_if lnk (.link_clk(link_clk));
  pixel_output_framer_blackcal u_pixel_output_framer_blackcal (.core_clk(core_clk), .resetn(resetn),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cfg_busy(cfg_busy), .src_valid(src_valid),
    .src_ready(src_ready), .src_black(src_black), .src_first(src_first), .src_last(src_last),
    .src_frame_first(src_frame_first), .src_frame_last(src_frame_last), .src_data(src_data), .lnk(lnk));
  pixel_link_receiver u_pixel_link_receiver (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .cfg_in(cfg), .cfg_load(cfg_load), .cfg_busy(), .rx_locked(rx_locked), .rx_valid(rx_valid),
    .rx_black(rx_black), .rx_first(), .rx_last(), .rx_frame(rx_frame), .rx_data(rx_data),
    .rx_chk_valid(rx_chk_valid), .rx_chk_ok(rx_chk_ok), .lnk(lnk));
  pixel_link_asserts u_pixel_link_asserts (.link_clk(link_clk), .resetn(resetn), .data(lnk.data),
    .sync(lnk.sync), .frame_valid(lnk.frame_valid), .line_valid(lnk.line_valid));
  // ------------------------------------------------
  // Receiver side capture
  // ------------------------------------------------
  always @(posedge link_clk) begin
    if (rx_valid === 1'b1) got.push_back(rx_data[39:30]);
    if (rx_valid === 1'b1 && rx_black === 1'b1) nblk <= nblk + 1;
    if (rx_chk_valid === 1'b1) nchk <= nchk + 1;
    if (lnk.line_valid === 1'b1 || lnk.frame_valid === 1'b1) lv_seen <= 1'b1;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic stop_test;
    $display("bad_count=%0d checked=%0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int i;
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    for (i = 0; i < 100; i++) begin
      @(posedge core_clk);
      #1;
      if (cfg_busy === 1'b0) break;
    end
    if (i == 100) begin
      bad_count++;
      stop_test();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    chk(reg_rdata, e);
  endtask : rd
  // One line of n equal words, frame flags left to the caller, checked at the receiver
  task automatic line(input logic blk, input logic [9:0] px, input int n, input logic [15:0] e);
    got.delete();
    nblk = 0;
    nchk = 0;
    @(posedge link_clk);
    for (int i = 0; i < n; i++) begin
      src_valid <= 1'b1;
      src_first <= (i == 0);
      src_last <= (i == n - 1);
      src_black <= blk;
      src_data <= {4{px}};
      @(posedge link_clk);
    end
    src_valid <= 1'b0;
    #1;
    chk({15'h0000, src_ready}, 16'h0000);
    repeat (8) @(posedge link_clk);
    chk({15'h0000, rx_chk_ok}, 16'h0001);
    chk(16'(nchk), 16'h0001);
    chk(16'(got.size()), 16'(n));
    chk(16'(nblk), 16'((blk && n > 2) ? n - 2 : 0));
    foreach (got[k]) chk({6'h00, got[k]}, e);
  endtask : line
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rd(8'h80 + 8'(i), pixel_framer_pkg::REG_RST[i]);
    rd(8'h88, 16'h0000);
    rd(8'h8a, 16'h0000);
    chk({15'h0000, rx_locked}, 16'h0001);
  endtask : t_reset
  task automatic t_auto;
    lv_seen = 1'b0;
    line(1'b1, 10'h014, 1, 16'h0014);
    chk({15'h0000, lv_seen}, 16'h0001);
    line(1'b0, 10'h064, 3, 16'h0058);
  endtask : t_auto
  task automatic t_err;
    wr(8'h80, 16'h0308);
    line(1'b1, 10'h014, 2, 16'h0008);
    rd(8'h88, 16'h000f);
    wr(8'h88, 16'h0000);
    rd(8'h88, 16'h000f);
    line(1'b0, 10'h064, 3, 16'h0058);
    wr(8'h80, 16'h4008);
    line(1'b1, 10'h014, 1, 16'h0008);
    rd(8'h88, 16'h0000);
  endtask : t_err
  task automatic t_manual;
    wr(8'h81, 16'hc00a);
    line(1'b0, 10'h064, 2, 16'h0069);
    wr(8'h81, 16'hc40a);
    line(1'b0, 10'h064, 1, 16'h005f);
    wr(8'h81, 16'he40a);
    line(1'b0, 10'h064, 2, 16'h0017);
    rd(8'h81, 16'he40a);
  endtask : t_manual
  task automatic t_gate;
    wr(8'h81, 16'h000a);
    repeat (4) @(posedge link_clk);
    lv_seen = 1'b0;
    line(1'b1, 10'h014, 3, 16'h0019);
    chk({15'h0000, lv_seen}, 16'h0000);
  endtask : t_gate
  task automatic t_kind;
    @(posedge link_clk);
    src_frame_last <= 1'b0;
    line(1'b0, 10'h064, 2, 16'h0017);
    chk({15'h0000, rx_frame}, 16'h0000);
    chk({15'h0000, lnk.frame_valid}, 16'h0001);
    src_frame_first <= 1'b0;
    src_frame_last <= 1'b1;
    line(1'b0, 10'h064, 2, 16'h0017);
    chk({15'h0000, rx_frame}, 16'h0001);
    chk({15'h0000, lnk.frame_valid}, 16'h0000);
    src_frame_first <= 1'b1;
  endtask : t_kind
  task automatic t_hold;
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(8'h82, 16'h0000);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(8'h82, 16'h03a6);
  endtask : t_hold
  initial begin
    {core_clk, link_clk, resetn, reg_wr, reg_rd, cfg_load, lv_seen} = 7'h00;
    {src_valid, src_black, src_first, src_last, reg_addr, reg_wdata, src_data} = '0;
    {clk_en, src_frame_first, src_frame_last} = 3'h7;
    cfg = {8'h08, 3'h0, 1'b1, 9'h000, 4'h3, 10'h3a6, 7'h2a, 10'h015, 10'h035, 10'h059, 10'h3a6};
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge link_clk);
    @(posedge core_clk);
    cfg_load <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
    repeat (30) @(posedge core_clk);
    t_reset();
    t_auto();
    t_err();
    t_manual();
    t_kind();
    t_gate();
    t_hold();
    stop_test();
  end
endmodule : pixel_output_framer_blackcal_tb
